// ===== mtcs_pkg.sv
// shared constants and types for the mac transmit control and status block
package mtcs_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] TXC_IDX = 12'h070;
    localparam logic [11:0] TXS_IDX = 12'h072;
    localparam logic [11:0] IST_IDX = 12'h080;
    localparam logic [11:0] IMSK_IDX = 12'h081;
    // transmit_control fields
    localparam int TXC_ICMP_B = 8;
    localparam int TXC_TCP_B = 6;
    localparam int TXC_IP_B = 5;
    localparam int TXC_FLUSH_B = 4;
    localparam int TXC_FC_B = 3;
    localparam int TXC_PAD_B = 2;
    localparam int TXC_CRC_B = 1;
    localparam int TXC_EN_B = 0;
    localparam logic [15:0] TXC_WMASK = 16'h017f;
    localparam logic [15:0] TXC_RST = 16'h0000;
    // transmit_status fields
    localparam int TXS_LC_B = 13;
    localparam int TXS_MC_B = 12;
    localparam int FID_W = 6;
    localparam logic [15:0] TXS_RST = 16'h0000;
    // interrupt status / mask fields
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE_B = 0;
    localparam int IRQ_LC_B = 1;
    localparam int IRQ_MC_B = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

    typedef enum logic [1:0] {
        MTCS_STOP = 2'b00,
        MTCS_RUN = 2'b01,
        MTCS_DRAIN = 2'b11
    } mtcs_run_t;

    typedef enum logic [2:0] {
        MTCS_SEL_TXC = 3'h0,
        MTCS_SEL_TXS = 3'h1,
        MTCS_SEL_IST = 3'h2,
        MTCS_SEL_IMSK = 3'h3,
        MTCS_SEL_NONE = 3'h4
    } mtcs_sel_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } mtcs_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mtcs_apb_rsp_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic late_col;
        logic max_col;
        logic [FID_W-1:0] fid;
    } mtcs_txev_t;

    typedef struct packed {
        logic full_duplex;
        logic rx_over_thresh;
        logic pause_sent;
    } mtcs_fc_in_t;

    typedef struct packed {
        logic icmp_csum_gen_en;
        logic tcp_csum_gen_en;
        logic ip_hdr_csum_gen_en;
        logic tx_queue_flush;
        logic tx_pad_en;
        logic tx_crc_append_en;
        logic tx_running;
        logic tx_start_ok;
        logic pause_req;
        logic backpressure;
    } mtcs_ctl_t;
endpackage

// ===== mtcs_tb_top.sv
// self-checking bench for the transmit control and status block
`timescale 1ns/1ps
`define CK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module mtcs_tb_top;
    import mtcs_pkg::*;
    localparam logic [11:0] A_TXC = TXC_IDX << 2;
    localparam logic [11:0] A_TXS = TXS_IDX << 2;
    localparam logic [11:0] A_IST = IST_IDX << 2;
    localparam logic [11:0] A_IMSK = IMSK_IDX << 2;
    logic core_clk;
    logic rst_b;
    mtcs_apb_req_t apb_i;
    mtcs_apb_rsp_t apb_o;
    mtcs_txev_t txev;
    mtcs_fc_in_t fc;
    mtcs_ctl_t ctl;
    logic irq;
    logic fd;
    logic thr;
    logic psent;
    int failures;
    int comparisons;
    logic [32:0] notes[$];
    logic [15:0] r;
    assign fc = {fd, thr, psent};
    mtcs_top dut_u (.core_clk(core_clk), .rst_b(rst_b), .apb_i(apb_i), .apb_o(apb_o),
        .txev_i(txev), .fc_i(fc), .ctl_o(ctl), .irq(irq));
    mtcs_txeng_model eng_u (.core_clk(core_clk), .ctl(ctl), .txev(txev), .pause_sent(psent));
    task automatic finish_test();
        if (failures == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one idle cycle after release keeps every drive to one assignment per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        apb_i <= '{1'b1, 1'b0, w, a, d, 4'hf};
        @(posedge core_clk);
        apb_i.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (apb_o.pready !== 1'b1 && n < 20);
        apb_i <= '0;
        if (n >= 20)
        begin
            failures++;
            $display("[ERR] %0t no pready", $time);
            finish_test();
        end
        else
            @(posedge core_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        notes.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // read results are matched in issue order against the driver's notes
    always @(posedge core_clk)
    begin
        if (apb_i.psel && apb_i.penable && apb_o.pready === 1'b1 && !apb_i.pwrite)
        begin
            if (notes.size() == 0)
                `CK(1'b1, 1'b0)
            else
                `CK({apb_o.pslverr, apb_o.prdata}, notes.pop_front())
        end
    end
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial
    begin
        rst_b = 1'b0;
        apb_i = '0;
        fd = 1'b0;
        thr = 1'b0;
        failures = 0;
        comparisons = 0;
        void'($urandom(67809));
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(A_TXC, 33'h0);
        rd(A_TXS, 33'h0);
        rd(12'h300, {1'b1, 32'h0});
        repeat (4)
        begin
            r = 16'($urandom);
            r[1] = r[1] | r[2];
            apb(1'b1, A_TXC, {16'h0, r & 16'hfffe});
            repeat (2) @(posedge core_clk);
            `CK(ctl.icmp_csum_gen_en, r[8])
            `CK(ctl.tcp_csum_gen_en, r[6])
            `CK(ctl.ip_hdr_csum_gen_en, r[5])
            `CK(ctl.tx_queue_flush, r[4])
            `CK(ctl.tx_pad_en, r[2])
            `CK(ctl.tx_crc_append_en, r[1])
            rd(A_TXC, {17'h0, r & 16'h017e});
        end
        apb(1'b1, A_TXC, 32'h0);
        apb(1'b1, A_IMSK, 32'h7);
        apb(1'b1, A_TXC, 32'h1);
        repeat (2) @(posedge core_clk);
        `CK({ctl.tx_running, ctl.tx_start_ok}, 2'b11)
        fork
            eng_u.send(6'h15, 1'b1, 1'b0, 14);
            begin
                repeat (2) @(posedge core_clk);
                apb(1'b1, A_TXC, 32'h0);
                repeat (2) @(posedge core_clk);
                `CK(ctl.tx_running, 1'b1)
            end
        join
        repeat (3) @(posedge core_clk);
        `CK({ctl.tx_running, irq}, 2'b01)
        rd(A_TXS, 33'h2015);
        rd(A_IST, 33'h3);
        repeat (2) @(posedge core_clk);
        `CK(irq, 1'b0)
        apb(1'b1, A_IMSK, 32'h0);
        apb(1'b1, A_TXC, 32'h1);
        eng_u.send(6'h2a, 1'b0, 1'b1, 3);
        repeat (3) @(posedge core_clk);
        `CK(irq, 1'b0)
        apb(1'b1, A_TXS, 32'hffff);
        rd(A_TXS, 33'h102a);
        rd(A_IST, 33'h5);
        apb(1'b1, A_TXC, 32'h0);
        apb(1'b1, A_TXC, 32'h10);
        repeat (2) @(posedge core_clk);
        `CK({ctl.tx_queue_flush, ctl.tx_start_ok}, 2'b10)
        apb(1'b1, A_TXC, 32'h8);
        fd <= 1'b1;
        thr <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CK({ctl.pause_req, ctl.backpressure}, 2'b10)
        repeat (10) @(posedge core_clk);
        `CK(ctl.pause_req, 1'b0)
        fd <= 1'b0;
        thr <= 1'b0;
        @(posedge core_clk);
        thr <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CK({ctl.pause_req, ctl.backpressure}, 2'b01)
        apb(1'b1, A_TXC, 32'h0);
        repeat (2) @(posedge core_clk);
        `CK({ctl.pause_req, ctl.backpressure}, 2'b00)
        repeat (4) @(posedge core_clk);
        finish_test();
    end
endmodule

// ===== mtcs_top.sv
// transmit control and status registers with run/stop sequencing and flow control
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - icmp checksum insertion enabled by control bit 8, unfragmented frames only
// - tcp checksum insertion enabled by control bit 6
// - ip header checksum insertion enabled by control bit 5
// - while bit 4 is set, queue memory cleared and frame pointer reset
// - flow control in full duplex sends pause when rx buffer nears overflow
// - flow control in half duplex applies back-pressure instead of pause
// - flow control bit clear means no transmit flow control at all
// - padding enable pads packets shorter than 64 bytes
// - crc enable appends a 32-bit crc to every frame
// - transmit enable set puts the transmitter into running state
// - enable cleared: finish current frame, then stop
// - status register holds only the last transmitted frame's outcome
// - late collision flag bit 13 set on late collision
// - maximum collision flag bit 12 set on maximum collision count
// - bits 5-0 name the frame; collision flags belong to it
module mtcs_top
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire mtcs_pkg::mtcs_apb_req_t apb_i,
    output mtcs_pkg::mtcs_apb_rsp_t apb_o,
    input wire mtcs_pkg::mtcs_txev_t txev_i,
    input wire mtcs_pkg::mtcs_fc_in_t fc_i,
    output mtcs_pkg::mtcs_ctl_t ctl_o,
    output logic irq
);
    import mtcs_pkg::*;

    typedef struct packed {
        logic [15:0] txc;
        logic [15:0] txs;
        logic [IRQ_W-1:0] ist;
        logic [IRQ_W-1:0] imsk;
        mtcs_run_t run;
        logic running;
        logic start_ok;
        logic pause_req;
        logic bp;
        logic thr_prev;
        mtcs_apb_rsp_t rsp;
        logic irq;
    } mtcs_state_t;

    localparam mtcs_state_t ST_RST = '{
        txc: TXC_RST,
        txs: TXS_RST,
        ist: IRQ_RST,
        imsk: IRQ_RST,
        run: MTCS_STOP,
        running: 1'b0,
        start_ok: 1'b0,
        pause_req: 1'b0,
        bp: 1'b0,
        thr_prev: 1'b0,
        rsp: '0,
        irq: 1'b0
    };

    mtcs_state_t s_q;
    mtcs_state_t s_d;

    // index match on the word address; low two address bits ignored
    function automatic mtcs_sel_t reg_sel(input logic [11:0] a);
        logic [9:0] idx;
        idx = a[11:2];
        if (idx == TXC_IDX[9:0])
            return MTCS_SEL_TXC;
        else if (idx == TXS_IDX[9:0])
            return MTCS_SEL_TXS;
        else if (idx == IST_IDX[9:0])
            return MTCS_SEL_IST;
        else if (idx == IMSK_IDX[9:0])
            return MTCS_SEL_IMSK;
        else
            return MTCS_SEL_NONE;
    endfunction

    logic acc;
    logic fin;
    logic rd_fin;
    logic wr_fin;
    mtcs_sel_t sel;
    logic [IRQ_W-1:0] ev;
    logic fc_en;
    logic thr_rise;

    assign acc = apb_i.psel & apb_i.penable;
    assign fin = acc & s_q.rsp.pready;
    assign rd_fin = fin & ~apb_i.pwrite;
    assign wr_fin = fin & apb_i.pwrite;
    assign sel = reg_sel(apb_i.paddr);
    assign fc_en = s_q.txc[TXC_FC_B];
    assign thr_rise = fc_i.rx_over_thresh & ~s_q.thr_prev;

    always_comb
    begin
        s_d = s_q;
        ev = '0;
        // one wait state: the answer is registered in the first access cycle
        s_d.rsp.pready = acc & ~s_q.rsp.pready;
        s_d.rsp.pslverr = 1'b0;
        s_d.rsp.prdata = '0;
        if (acc & ~s_q.rsp.pready)
        begin
            s_d.rsp.pslverr = (sel == MTCS_SEL_NONE);
            case (sel)
                MTCS_SEL_TXC: s_d.rsp.prdata = {16'h0000, s_q.txc};
                MTCS_SEL_TXS: s_d.rsp.prdata = {16'h0000, s_q.txs};
                MTCS_SEL_IST: s_d.rsp.prdata = {29'h0, s_q.ist};
                MTCS_SEL_IMSK: s_d.rsp.prdata = {29'h0, s_q.imsk};
                default: s_d.rsp.prdata = '0;
            endcase
        end

        // writes land only at the completing edge
        if (wr_fin && sel == MTCS_SEL_TXC)
        begin
            if (apb_i.pstrb[0])
                s_d.txc[7:0] = apb_i.pwdata[7:0] & TXC_WMASK[7:0];
            if (apb_i.pstrb[1])
                s_d.txc[15:8] = apb_i.pwdata[15:8] & TXC_WMASK[15:8];
        end
        if (wr_fin && sel == MTCS_SEL_IMSK && apb_i.pstrb[0])
            s_d.imsk = apb_i.pwdata[IRQ_W-1:0];

        // frame completion replaces the whole status word at once
        if (txev_i.done)
        begin
            s_d.txs = TXS_RST;
            s_d.txs[TXS_LC_B] = txev_i.late_col;
            s_d.txs[TXS_MC_B] = txev_i.max_col;
            s_d.txs[FID_W-1:0] = txev_i.fid;
        end

        ev[IRQ_DONE_B] = txev_i.done;
        ev[IRQ_LC_B] = txev_i.done & txev_i.late_col;
        ev[IRQ_MC_B] = txev_i.done & txev_i.max_col;
        // read clears, but an event in the same cycle survives
        if (rd_fin && sel == MTCS_SEL_IST)
            s_d.ist = '0;
        s_d.ist = s_d.ist | ev;

        // graceful stop: a frame already on the wire is never cut short
        case (s_q.run)
            MTCS_STOP:
                if (s_q.txc[TXC_EN_B])
                    s_d.run = MTCS_RUN;
            MTCS_RUN:
                if (!s_q.txc[TXC_EN_B])
                    s_d.run = txev_i.busy ? MTCS_DRAIN : MTCS_STOP;
            MTCS_DRAIN:
                if (!txev_i.busy)
                    s_d.run = MTCS_STOP;
                else if (s_q.txc[TXC_EN_B])
                    s_d.run = MTCS_RUN;
            default:
                s_d.run = MTCS_STOP;
        endcase
        s_d.running = (s_d.run != MTCS_STOP);
        // new frames may start only while running and not flushing
        s_d.start_ok = (s_d.run == MTCS_RUN) & ~s_d.txc[TXC_FLUSH_B];

        // pause is requested once per threshold crossing
        s_d.thr_prev = fc_i.rx_over_thresh;
        if (!fc_en || !fc_i.full_duplex)
            s_d.pause_req = 1'b0;
        else if (thr_rise)
            s_d.pause_req = 1'b1;
        else if (fc_i.pause_sent)
            s_d.pause_req = 1'b0;
        s_d.bp = fc_en & ~fc_i.full_duplex & fc_i.rx_over_thresh;

        s_d.irq = |(s_d.ist & s_d.imsk);
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= ST_RST;
        else
            s_q <= s_d;
    end

    assign apb_o = s_q.rsp;
    assign irq = s_q.irq;
    assign ctl_o.icmp_csum_gen_en = s_q.txc[TXC_ICMP_B];
    assign ctl_o.tcp_csum_gen_en = s_q.txc[TXC_TCP_B];
    assign ctl_o.ip_hdr_csum_gen_en = s_q.txc[TXC_IP_B];
    assign ctl_o.tx_queue_flush = s_q.txc[TXC_FLUSH_B];
    assign ctl_o.tx_pad_en = s_q.txc[TXC_PAD_B];
    assign ctl_o.tx_crc_append_en = s_q.txc[TXC_CRC_B];
    assign ctl_o.tx_running = s_q.running;
    assign ctl_o.tx_start_ok = s_q.start_ok;
    assign ctl_o.pause_req = s_q.pause_req;
    assign ctl_o.backpressure = s_q.bp;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_frame_done;
        txev_i.done;
    endsequence

    sequence s_answer;
        apb_o.pready ##1 !apb_o.pready;
    endsequence

    property p_apb_answer;
        acc && !apb_o.pready |=> s_answer;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not one cycle after access");

    property p_status_id;
        s_frame_done |=> s_q.txs[FID_W-1:0] == $past(txev_i.fid)
            && s_q.txs[11:6] == 6'h00;
    endproperty
    a_status_id: assert property (p_status_id)
        else $error("frame id not captured at completion");

    property p_late_col;
        s_frame_done ##0 txev_i.late_col |=> s_q.txs[TXS_LC_B] && s_q.ist[IRQ_LC_B];
    endproperty
    a_late_col: assert property (p_late_col)
        else $error("late collision not reported");

    property p_max_col;
        s_frame_done ##0 !txev_i.max_col |=> !s_q.txs[TXS_MC_B];
    endproperty
    a_max_col: assert property (p_max_col)
        else $error("stale max collision flag");

    property p_hold_status;
        !txev_i.done |=> $stable(s_q.txs);
    endproperty
    a_hold_status: assert property (p_hold_status)
        else $error("status changed without a completed frame");

    property p_drain;
        s_q.run == MTCS_RUN && !s_q.txc[TXC_EN_B] && txev_i.busy
            |=> s_q.run == MTCS_DRAIN && ctl_o.tx_running;
    endproperty
    a_drain: assert property (p_drain)
        else $error("stopped during a frame");

    property p_start;
        s_q.run == MTCS_STOP && s_q.txc[TXC_EN_B] |=> ctl_o.tx_running;
    endproperty
    a_start: assert property (p_start)
        else $error("enable did not start the transmitter");

    property p_pause;
        fc_en && fc_i.full_duplex && thr_rise |=> ctl_o.pause_req;
    endproperty
    a_pause: assert property (p_pause)
        else $error("pause not requested at threshold");

    property p_bp;
        fc_en && !fc_i.full_duplex && fc_i.rx_over_thresh
            |=> ctl_o.backpressure && !ctl_o.pause_req;
    endproperty
    a_bp: assert property (p_bp)
        else $error("back-pressure missing in half duplex");

    property p_no_fc;
        !fc_en ##1 !fc_en |-> !ctl_o.backpressure && !ctl_o.pause_req;
    endproperty
    a_no_fc: assert property (p_no_fc)
        else $error("flow control active while disabled");

    property p_reserved;
        wr_fin && sel == MTCS_SEL_TXC |=> s_q.txc[15:9] == 7'h00 && !s_q.txc[7];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved control bits took a write");
endmodule

// ===== mtcs_txeng_model.sv
// transmitter-side model: frame completion events and pause frame launch
`timescale 1ns/1ps
module mtcs_txeng_model
    import mtcs_pkg::*;
(
    input wire logic core_clk,
    input wire mtcs_ctl_t ctl,
    output mtcs_txev_t txev,
    output logic pause_sent
);
    int cnt;
    initial
    begin
        txev = '0;
        pause_sent = 1'b0;
        cnt = 0;
    end
    // one frame: busy for len cycles, then a done pulse with its result
    task automatic send(input logic [5:0] id, input logic lc, input logic mc, input int len);
        txev.busy <= 1'b1;
        repeat (len) @(posedge core_clk);
        txev <= '{1'b0, 1'b1, lc, mc, id};
        @(posedge core_clk);
        // qualifiers mean nothing without done, so they are left at their complements afterwards
        txev <= '{1'b0, 1'b0, ~lc, ~mc, ~id};
    endtask
    // the pause frame leaves a few cycles after the request, not at once
    always @(posedge core_clk)
    begin
        cnt <= (ctl.pause_req && !pause_sent) ? cnt + 1 : 0;
        pause_sent <= (cnt == 3);
    end
endmodule
